// [hw/fdc_map.vh]
// constants, register map and timing counts of the floppy command core
`ifndef FDC_MAP_VH
`define FDC_MAP_VH
`define OFF_CMD      8'h00
`define OFF_TRK      8'h04
`define OFF_SEC      8'h08
`define OFF_DAT      8'h0c
`define OFF_CFG      8'h10
`define CFG_SIDE_OUT 0
`define CFG_SLOW     1
`define CFG_LEN_LO   2
`define CFG_LAST_LO  8
`define ST_BUSY      0
`define ST_DRQ       1
`define ST_SIDE      3
`define ST_SEEK      4
`define ST_ERR       5
`define ST_WPROT     6
`define ST_NOTRDY    7
`define C_RESTORE    4'h0
`define C_SEEK       4'h1
`define C_STEP       4'h2
`define C_STEPIN     4'h3
`define C_STEPOUT    4'h4
`define C_RDSEC      4'h5
`define C_WRSEC      4'h6
`define C_RDADR      4'h7
`define C_RDTRK      4'h8
`define C_WRTRK      4'h9
`define C_FORCE      4'ha
`define T_ONE        2'h0
`define T_TWO        2'h1
`define T_THREE      2'h2
`define T_FOUR       2'h3
`define INNER_LO     8'h2c
`define INNER_HI     8'h4c
`define MARK_DATA    8'hfb
`define MARK_DEL     8'hf8
`define STEP_LIMIT   8'hff
`define CLK_KHZ      23'h1e848
`define SETTLE_MS    23'hf
`define SETTLE_SLOW_MS 23'h1e
`define STEP_BASE_MS 23'h3
`define PRECOMP_CYC  4'h1
`define HALF_CELL_CYC 4'h8
`define FM_MISSING   8'h38
`define MFM_MISSING  8'h04
`endif

// [hw/fdc_cmd_decode.v]
// command word decoder: command code and command type
`timescale 1ns/1ps
`include "fdc_map.vh"
module fdc_cmd_decode (
  // command word
  input  wire [7:0] cmd,
  // decoded result
  output reg  [3:0] code,
  output reg  [1:0] ctype
);
  always @* begin
    code  = `C_RESTORE;
    ctype = `T_ONE;
    casez (cmd[7:3])
      5'b0000?: code = `C_RESTORE;
      5'b0001?: code = `C_SEEK;
      5'b001??: code = `C_STEP;
      5'b010??: code = `C_STEPIN;
      5'b011??: code = `C_STEPOUT;
      5'b100??: begin
        code  = `C_RDSEC;
        ctype = `T_TWO;
      end
      5'b101??: begin
        code  = `C_WRSEC;
        ctype = `T_TWO;
      end
      5'b11000: begin
        code  = `C_RDADR;
        ctype = `T_THREE;
      end
      5'b11100: begin
        code  = `C_RDTRK;
        ctype = `T_THREE;
      end
      5'b11110: begin
        code  = `C_WRTRK;
        ctype = `T_THREE;
      end
      5'b1101?: begin
        code  = `C_FORCE;
        ctype = `T_FOUR;
      end
      default: begin
        code  = `C_RDTRK;
        ctype = `T_THREE;
      end
    endcase
  end
endmodule // fdc_cmd_decode

// [hw/fdc_mark_writer.v]
// serial write data encoder with clock and data pulses and address marks
`timescale 1ns/1ps
`include "fdc_map.vh"
module fdc_mark_writer (
  // clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // byte request
  input  wire       start,
  input  wire [7:0] byte_in,
  input  wire       mark,
  input  wire       dden,
  // serial side
  output reg        wdata,
  output reg        busy
);
  reg [7:0] sh;
  reg [7:0] missing;
  reg [2:0] bit_n;
  reg [3:0] cyc;
  reg       half;
  reg       prev;
  reg       fm;
  wire      clk_bit  = fm ? 1'b1 : (~prev & ~sh[7]);
  wire      slot_bit = half ? sh[7] : (clk_bit & ~missing[7]);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sh      <= 8'h00;
      missing <= 8'h00;
      bit_n   <= 3'h0;
      cyc     <= 4'h0;
      half    <= 1'b0;
      prev    <= 1'b0;
      fm      <= 1'b1;
      busy    <= 1'b0;
      wdata   <= 1'b0;
    end else begin
      // pulse lasts three precomp steps so early/late shifts stay inside it
      wdata <= busy & slot_bit & (cyc < 3 * `PRECOMP_CYC);
      if (start && !busy) begin
        sh      <= byte_in;
        fm      <= ~dden;
        missing <= mark ? (dden ? `MFM_MISSING : `FM_MISSING) : 8'h00;
        bit_n   <= 3'h0;
        cyc     <= 4'h0;
        half    <= 1'b0;
        busy    <= 1'b1;
      end else if (busy) begin
        if (cyc == `HALF_CELL_CYC - 4'h1) begin
          cyc  <= 4'h0;
          half <= ~half;
          if (half) begin
            prev    <= sh[7];
            sh      <= {sh[6:0], 1'b0};
            missing <= {missing[6:0], 1'b0};
            bit_n   <= bit_n + 3'h1;
            if (bit_n == 3'h7)
              busy <= 1'b0;
          end
        end else begin
          cyc <= cyc + 4'h1;
        end
      end
    end
  end
endmodule // fdc_mark_writer

// [hw/fdc_command_core.v]
// floppy command interpreter with apb registers, stepping and write sequencing
`timescale 1ns/1ps
`include "fdc_map.vh"
module fdc_command_core #(
  parameter [22:0] SETTLE_CYC      = `SETTLE_MS * `CLK_KHZ,
  parameter [22:0] SETTLE_SLOW_CYC = `SETTLE_SLOW_MS * `CLK_KHZ,
  parameter [22:0] STEP_CYC        = `STEP_BASE_MS * `CLK_KHZ
) (
  // clock and reset
  input  wire        REF_CLK,
  input  wire        RST_N,
  // apb slave
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [7:0]  PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output wire        PREADY,
  output wire        PSLVERR,
  // drive inputs
  input  wire        READY_IN,
  input  wire        WPROT_N,
  input  wire        INDEX_N,
  input  wire        TRK0_N,
  input  wire        SIDE_ID_IN,
  input  wire        DDEN_N,
  // drive outputs
  output reg         STEP_OUT,
  output reg         DIR_OUT,
  output reg         HEAD_LOAD_OUT,
  output reg         SIDE_SELECT_OUT,
  output reg         INNER_TRACK_FLAG,
  output reg         WRITE_GATE_OUT,
  output wire        WRITE_DATA_OUT,
  // host interrupt
  output reg         INTERRUPT_REQUEST_LINE
);
  localparam [2:0] S_IDLE   = 3'h0;
  localparam [2:0] S_STEP   = 3'h1;
  localparam [2:0] S_VERIFY = 3'h2;
  localparam [2:0] S_SETTLE = 3'h3;
  localparam [2:0] S_XFER   = 3'h4;
  localparam [2:0] S_END    = 3'h5;

  reg  [1:0]  rst_q;
  wire        rst_n = rst_q[1];
  reg  [5:0]  sync1;
  reg  [5:0]  sync2;
  reg         ready_d;
  reg         index_d;
  reg  [2:0]  state;
  reg  [7:0]  cmd;
  reg  [3:0]  code;
  reg  [7:0]  trk;
  reg  [7:0]  sec;
  reg  [7:0]  dat;
  reg  [15:0] cfg;
  reg  [22:0] timer;
  reg  [7:0]  steps;
  reg         stepped;
  reg         busy;
  reg         side_err;
  reg         seek_err;
  reg         wp_err;
  reg         notrdy;
  reg         side_expect;
  reg  [2:0]  arm;
  reg         data_full;
  reg         first;
  reg         idx_seen;
  reg  [10:0] cnt;
  reg         wr_start;
  reg  [7:0]  wr_byte;
  reg         wr_mark;
  reg  [7:0]  status;
  reg  [31:0] next_rdata;
  wire        wr_busy;
  wire [3:0]  dec_code;
  wire [1:0]  dec_type;

  wire ready_s  = sync2[5];
  wire wprot_s  = sync2[4];
  wire index_s  = sync2[3];
  wire trk0_s   = sync2[2];
  wire side_s   = sync2[1];
  wire dden_s   = ~sync2[0];
  wire side_var = cfg[`CFG_SIDE_OUT];
  wire [7:0] last_sec = cfg[`CFG_LAST_LO+7:`CFG_LAST_LO];
  wire [1:0] len_code = cfg[`CFG_LEN_LO+1:`CFG_LEN_LO];

  wire access   = PSEL & PENABLE;
  wire apb_wr   = access & PWRITE;
  wire mapped   = (PADDR == `OFF_CMD) | (PADDR == `OFF_TRK) | (PADDR == `OFF_SEC) |
                  (PADDR == `OFF_DAT) | (PADDR == `OFF_CFG);
  assign PREADY  = 1'b1;
  assign PSLVERR = access & ~mapped;

  // commands other than force are dropped while busy
  wire cmd_wr   = apb_wr & (PADDR == `OFF_CMD) & (~busy | (dec_code == `C_FORCE));
  wire stat_rd  = access & ~PWRITE & (PADDR == `OFF_CMD);
  wire dat_wr   = apb_wr & (PADDR == `OFF_DAT);

  wire ready_rise = ready_s & ~ready_d;
  wire ready_fall = ~ready_s & ready_d;
  wire index_fall = ~index_s & index_d;
  wire force_imm  = cmd_wr & (dec_code == `C_FORCE) & PWDATA[3];
  wire arm_evt    = (arm[0] & ready_rise) | (arm[1] & ready_fall) |
                    (arm[2] & index_fall);
  wire irq_set    = (state == S_END) | force_imm | arm_evt;
  wire drq        = (state == S_XFER) & ~data_full;
  wire is_write   = (code == `C_WRSEC) | (code == `C_WRTRK);
  wire is_step    = (code == `C_STEP) | (code == `C_STEPIN) | (code == `C_STEPOUT);

  // sector byte count from id length code and selected table
  function [10:0] sector_len;
    input       table_sel;
    input [1:0] id_code;
    begin
      if (table_sel)
        sector_len = 11'h080 << id_code;
      else if (id_code == 2'h3)
        sector_len = 11'h080;
      else
        sector_len = 11'h100 << id_code;
    end
  endfunction

  // older variant has no length flag and always uses the second table
  wire [10:0] rec_len = sector_len(side_var ? cmd[3] : 1'b1, len_code);

  fdc_cmd_decode u_decode (
    .cmd   (PWDATA[7:0]),
    .code  (dec_code),
    .ctype (dec_type)
  );

  fdc_mark_writer u_writer (
    .clk     (REF_CLK),
    .rst_n   (rst_n),
    .start   (wr_start),
    .byte_in (wr_byte),
    .mark    (wr_mark),
    .dden    (dden_s),
    .wdata   (WRITE_DATA_OUT),
    .busy    (wr_busy)
  );

  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N)
      rst_q <= 2'b00;
    else
      rst_q <= {rst_q[0], 1'b1};
  end

  // drive pins are asynchronous; only the second stage is looked at
  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sync1   <= 6'h3f;
      sync2   <= 6'h3f;
      ready_d <= 1'b1;
      index_d <= 1'b1;
    end else begin
      sync1   <= {READY_IN, WPROT_N, INDEX_N, TRK0_N, SIDE_ID_IN, DDEN_N};
      sync2   <= sync1;
      ready_d <= ready_s;
      index_d <= index_s;
    end
  end

  always @* begin
    status = 8'h00;
    status[`ST_BUSY]   = busy;
    status[`ST_DRQ]    = drq;
    status[`ST_SIDE]   = side_err;
    status[`ST_SEEK]   = seek_err;
    status[`ST_ERR]    = side_err | seek_err | wp_err | notrdy;
    status[`ST_WPROT]  = wp_err;
    status[`ST_NOTRDY] = notrdy;
    case (PADDR)
      `OFF_CMD: next_rdata = {24'h000000, status};
      `OFF_TRK: next_rdata = {24'h000000, trk};
      `OFF_SEC: next_rdata = {24'h000000, sec};
      `OFF_DAT: next_rdata = {24'h000000, dat};
      `OFF_CFG: next_rdata = {16'h0000, cfg};
      default:  next_rdata = 32'h00000000;
    endcase
  end

  // read data is captured in the setup cycle so it is stable for the access phase
  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n)
      PRDATA <= 32'h00000000;
    else if (PSEL && !PENABLE && !PWRITE)
      PRDATA <= next_rdata;
  end

  // a new event wins over a clear in the same cycle
  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n)
      INTERRUPT_REQUEST_LINE <= 1'b0;
    else if (irq_set)
      INTERRUPT_REQUEST_LINE <= 1'b1;
    else if (stat_rd || cmd_wr)
      INTERRUPT_REQUEST_LINE <= 1'b0;
  end

  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      cmd <= 8'h00;
      code <= `C_RESTORE;
      trk <= 8'h00;
      sec <= 8'h00;
      dat <= 8'h00;
      cfg <= 16'h0000;
      timer <= 23'h000000;
      steps <= 8'h00;
      stepped <= 1'b0;
      busy <= 1'b0;
      side_err <= 1'b0;
      seek_err <= 1'b0;
      wp_err <= 1'b0;
      notrdy <= 1'b0;
      side_expect <= 1'b0;
      arm <= 3'h0;
      data_full <= 1'b0;
      first <= 1'b0;
      idx_seen <= 1'b0;
      cnt <= 11'h000;
      wr_start <= 1'b0;
      wr_byte <= 8'h00;
      wr_mark <= 1'b0;
      STEP_OUT <= 1'b0;
      DIR_OUT <= 1'b0;
      HEAD_LOAD_OUT <= 1'b0;
      SIDE_SELECT_OUT <= 1'b0;
      INNER_TRACK_FLAG <= 1'b0;
      WRITE_GATE_OUT <= 1'b0;
    end else begin
      STEP_OUT <= 1'b0;
      wr_start <= 1'b0;
      if (apb_wr && PADDR == `OFF_TRK)
        trk <= PWDATA[7:0];
      if (apb_wr && PADDR == `OFF_SEC)
        sec <= PWDATA[7:0];
      if (apb_wr && PADDR == `OFF_CFG)
        cfg <= PWDATA[15:0];
      if (dat_wr) begin
        dat <= PWDATA[7:0];
        data_full <= 1'b1;
      end
      if (state == S_XFER && index_fall)
        idx_seen <= 1'b1;
      case (state)
        S_STEP: begin
          if (timer != 23'h000000) begin
            timer <= timer - 23'h000001;
          end else if (code == `C_RESTORE || code == `C_SEEK) begin
            if (code == `C_RESTORE ? !trk0_s : trk == dat) begin
              if (code == `C_RESTORE)
                trk <= 8'h00;
              state <= cmd[2] ? S_VERIFY : S_END;
              timer <= SETTLE_CYC;
            end else if (steps == `STEP_LIMIT) begin
              seek_err <= 1'b1;
              state <= S_END;
            end else begin
              DIR_OUT <= (code == `C_SEEK) & (dat > trk);
              if (code == `C_SEEK)
                trk <= (dat > trk) ? trk + 8'h01 : trk - 8'h01;
              STEP_OUT <= 1'b1;
              steps <= steps + 8'h01;
              timer <= STEP_CYC * {21'h000000, cmd[1:0]} + STEP_CYC;
            end
          end else if (!stepped) begin
            if (code != `C_STEP)
              DIR_OUT <= (code == `C_STEPIN);
            STEP_OUT <= 1'b1;
            stepped <= 1'b1;
            if (cmd[4]) begin
              if (code == `C_STEPOUT || (code == `C_STEP && !DIR_OUT))
                trk <= trk - 8'h01;
              else
                trk <= trk + 8'h01;
            end
            timer <= STEP_CYC * {21'h000000, cmd[1:0]} + STEP_CYC;
          end else begin
            state <= cmd[2] ? S_VERIFY : S_END;
            timer <= SETTLE_CYC;
          end
        end
        S_VERIFY: begin
          if (timer != 23'h000000) begin
            timer <= timer - 23'h000001;
          end else begin
            // the side-output variant never compares sides on a verify
            if (!side_var && side_s != side_expect)
              side_err <= 1'b1;
            state <= S_END;
          end
        end
        S_SETTLE: begin
          if (timer != 23'h000000) begin
            timer <= timer - 23'h000001;
          end else if (!is_write) begin
            state <= S_END;
          end else if (!wprot_s) begin
            wp_err <= 1'b1;
            state <= S_END;
          end else begin
            WRITE_GATE_OUT <= 1'b1;
            state <= S_XFER;
          end
        end
        S_XFER: begin
          if (!wprot_s) begin
            wp_err <= 1'b1;
            WRITE_GATE_OUT <= 1'b0;
            state <= S_END;
          end else if (!wr_busy && !wr_start) begin
            if (first) begin
              wr_byte <= cmd[0] ? `MARK_DEL : `MARK_DATA;
              wr_mark <= 1'b1;
              wr_start <= 1'b1;
              first <= 1'b0;
            end else if (code == `C_WRTRK && idx_seen) begin
              WRITE_GATE_OUT <= 1'b0;
              state <= S_END;
            end else if (code == `C_WRSEC && cnt == rec_len) begin
              if (cmd[4] && sec != last_sec) begin
                sec <= sec + 8'h01;
                cnt <= 11'h000;
                first <= 1'b1;
              end else begin
                WRITE_GATE_OUT <= 1'b0;
                state <= S_END;
              end
            end else if (data_full && !dat_wr) begin
              wr_byte <= dat;
              wr_mark <= 1'b0;
              wr_start <= 1'b1;
              data_full <= 1'b0;
              cnt <= cnt + 11'h001;
            end
          end
        end
        S_END: begin
          busy <= 1'b0;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
      if (cmd_wr && dec_code == `C_FORCE) begin
        arm <= PWDATA[2:0];
        busy <= 1'b0;
        WRITE_GATE_OUT <= 1'b0;
        state <= S_IDLE;
      end else if (cmd_wr) begin
        cmd <= PWDATA[7:0];
        code <= dec_code;
        busy <= 1'b1;
        arm <= 3'h0;
        side_err <= 1'b0;
        seek_err <= 1'b0;
        wp_err <= 1'b0;
        notrdy <= 1'b0;
        data_full <= 1'b0;
        idx_seen <= 1'b0;
        cnt <= 11'h000;
        first <= (dec_code == `C_WRSEC);
        steps <= 8'h00;
        stepped <= 1'b0;
        if (dec_type == `T_ONE) begin
          HEAD_LOAD_OUT <= ~PWDATA[3];
          timer <= 23'h000000;
          state <= S_STEP;
        end else begin
          INNER_TRACK_FLAG <= (trk >= `INNER_LO) && (trk <= `INNER_HI);
          side_expect <= PWDATA[3];
          if (side_var)
            SIDE_SELECT_OUT <= PWDATA[1];
          if (!ready_s) begin
            notrdy <= 1'b1;
            state <= S_END;
          end else if (!side_var && dec_type == `T_TWO && PWDATA[1] &&
                       side_s != PWDATA[3]) begin
            side_err <= 1'b1;
            state <= S_END;
          end else begin
            if (!PWDATA[2])
              timer <= 23'h000000;
            else if (cfg[`CFG_SLOW])
              timer <= SETTLE_SLOW_CYC;
            else
              timer <= SETTLE_CYC;
            state <= S_SETTLE;
          end
        end
      end
    end
  end
endmodule // fdc_command_core

// [bench/fdc_drive_model.sv]
// drive mechanics model: head position, track 0 sensor and index pulses
`timescale 1ns/1ps
module fdc_drive_model (
  // drive side
  input  wire REF_CLK,
  input  wire STEP_OUT,
  input  wire DIR_OUT,
  output wire TRK0_N,
  output wire INDEX_N
);
  integer pos = 2;
  integer rev = 0;
  // the head cannot move below track 0, so extra outward steps are lost
  always @(posedge REF_CLK) begin
    if (STEP_OUT)
      pos <= DIR_OUT ? pos + 1 : (pos > 0 ? pos - 1 : 0);
    rev <= (rev == 499) ? 0 : rev + 1;
  end
  assign TRK0_N  = (pos != 0);
  assign INDEX_N = (rev > 3);
endmodule // fdc_drive_model

// [bench/fdc_command_core_properties.sv]
// concurrent checks on the command core ports
`timescale 1ns/1ps
module fdc_command_core_properties (
  // watched ports
  input wire        REF_CLK,
  input wire        RST_N,
  input wire        PSEL,
  input wire        PENABLE,
  input wire        PWRITE,
  input wire [7:0]  PADDR,
  input wire [31:0] PWDATA,
  input wire        READY_IN,
  input wire        WPROT_N,
  input wire        STEP_OUT,
  input wire        SIDE_SELECT_OUT,
  input wire        INNER_TRACK_FLAG,
  input wire        WRITE_GATE_OUT,
  input wire        INTERRUPT_REQUEST_LINE
);
  wire acc0 = PSEL && PENABLE && PADDR == 8'h00;
  wire frc  = acc0 && PWRITE && PWDATA[7:4] == 4'hd;
  wire rw   = acc0 && PWRITE && PWDATA[7] && !frc;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  sequence s_late_cmd; !READY_IN [*4] ##0 rw; endsequence
  sequence s_guarded; !WPROT_N [*5]; endsequence
  property p_irq_hold; INTERRUPT_REQUEST_LINE && !acc0 |=> INTERRUPT_REQUEST_LINE; endproperty
  property p_cmd_clear; acc0 && PWRITE && !(frc && PWDATA[3]) |=> !INTERRUPT_REQUEST_LINE;
  endproperty
  property p_force_now; frc && PWDATA[3] |-> ##[1:4] INTERRUPT_REQUEST_LINE; endproperty
  property p_force_quiet; frc && PWDATA[3:0] == 4'h0 |=> !INTERRUPT_REQUEST_LINE [*4];
  endproperty
  property p_not_ready; s_late_cmd |-> ##[1:4] INTERRUPT_REQUEST_LINE; endproperty
  property p_inner; !$stable(INNER_TRACK_FLAG) |-> $past(rw) || $past(rw, 2) || $past(rw, 3);
  endproperty
  property p_guard; s_guarded |-> !WRITE_GATE_OUT; endproperty
  property p_side_hold; STEP_OUT |-> $stable(SIDE_SELECT_OUT); endproperty
  property p_step_gap; STEP_OUT |=> !STEP_OUT [*8]; endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("interrupt fell with no clearing access");
  a_cmd_clear: assert property (p_cmd_clear)
    else $error("command write left interrupt set");
  a_force_now: assert property (p_force_now)
    else $error("immediate force gave no interrupt");
  a_force_quiet: assert property (p_force_quiet)
    else $error("plain force raised interrupt");
  a_not_ready: assert property (p_not_ready)
    else $error("not ready command gave no interrupt");
  a_inner: assert property (p_inner)
    else $error("inner track flag moved without command");
  a_guard: assert property (p_guard)
    else $error("write gate on while protected");
  a_side_hold: assert property (p_side_hold)
    else $error("side output moved on a step");
  a_step_gap: assert property (p_step_gap)
    else $error("step pulses too close");
endmodule // fdc_command_core_properties
bind fdc_command_core fdc_command_core_properties fdc_command_core_properties_i (
  .REF_CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .READY_IN, .WPROT_N,
  .STEP_OUT, .SIDE_SELECT_OUT, .INNER_TRACK_FLAG, .WRITE_GATE_OUT, .INTERRUPT_REQUEST_LINE);

// [bench/floppy_command_decoder_test.sv]
// self-checking bench for the floppy command core
`timescale 1ns/1ps
`include "fdc_map.vh"
module floppy_command_decoder_test;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic s;} row_t;
  logic        REF_CLK  = 1'b0;
  logic        RST_N    = 1'b0;
  logic        PSEL     = 1'b0;
  logic        PENABLE  = 1'b0;
  logic        PWRITE   = 1'b0;
  logic [7:0]  PADDR    = 8'h00;
  logic [31:0] PWDATA   = 32'h0;
  logic        READY_IN = 1'b1;
  logic        WPROT_N  = 1'b1;
  wire  [31:0] PRDATA;
  wire PREADY, PSLVERR, TRK0_N, INDEX_N, STEP_OUT, DIR_OUT, HEAD_LOAD_OUT, SIDE_SELECT_OUT;
  wire INNER_TRACK_FLAG, WRITE_GATE_OUT, WRITE_DATA_OUT, INTERRUPT_REQUEST_LINE;
  logic [31:0] rd;
  logic        err;
  integer      bad_count = 0;
  integer      compares  = 0;
  integer      steps     = 0;
  integer      i, n, base;
  // register rows: cfg keeps the side output variant selected
  row_t rows [5] = '{'{8'h04, 32'h4d, 32'h4d, 1'b0}, '{8'h08, 32'h1ff, 32'hff, 1'b0},
    '{8'h0c, 32'h03, 32'h03, 1'b0}, '{8'h10, 32'hffff0305, 32'h0305, 1'b0},
    '{8'h14, 32'h55, 32'h0, 1'b1}};
  logic [7:0]  trk [4]   = '{8'h2b, 8'h2c, 8'h4c, 8'h4d};
  logic        inner [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  // command, track after, step count, direction
  logic [23:0] st [6] = '{24'h080020, 24'h150331, 24'h520411, 24'h7b0310, 24'h200310,
    24'h300210};
  fdc_command_core #(.SETTLE_CYC(23'd20), .SETTLE_SLOW_CYC(23'd40), .STEP_CYC(23'd10))
    fdc_command_core_i (.REF_CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
    .PRDATA, .PREADY, .PSLVERR, .READY_IN, .WPROT_N, .INDEX_N, .TRK0_N, .SIDE_ID_IN(1'b0),
    .DDEN_N(1'b0), .STEP_OUT, .DIR_OUT, .HEAD_LOAD_OUT, .SIDE_SELECT_OUT, .INNER_TRACK_FLAG,
    .WRITE_GATE_OUT, .WRITE_DATA_OUT, .INTERRUPT_REQUEST_LINE);
  fdc_drive_model fdc_drive_model_i (.REF_CLK, .STEP_OUT, .DIR_OUT, .TRK0_N, .INDEX_N);
  always #4 REF_CLK = ~REF_CLK;
  always @(posedge REF_CLK) begin
    if (STEP_OUT === 1'b1)
      steps <= steps + 1;
  end
  task final_report;
    begin
      if (bad_count == 0 && compares > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  // one apb transfer; returns one edge after the access so outputs have settled
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
      @(posedge REF_CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge REF_CLK);
      PENABLE <= 1'b1;
      @(posedge REF_CLK);
      while (PREADY !== 1'b1) @(posedge REF_CLK);
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge REF_CLK);
    end
  endtask
  task wait_irq(input integer lim);
    begin
      n = 0;
      while (INTERRUPT_REQUEST_LINE !== 1'b1 && n < lim) begin
        @(posedge REF_CLK);
        n = n + 1;
      end
      chk(INTERRUPT_REQUEST_LINE, 1'b1, "irq");
    end
  endtask
  initial begin
    #400000;
    bad_count = bad_count + 1;
    final_report;
  end
  initial begin
    repeat (16) @(posedge REF_CLK);
    RST_N <= 1'b1;
    repeat (3) @(posedge REF_CLK);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd[`ST_BUSY], 1'b0, "busy");
    for (i = 0; i < 5; i++) begin
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      chk(rd, rows[i].e, "rdata");
      chk(err, rows[i].s, "slverr");
    end
    for (i = 0; i < 4; i++) begin
      apb(1'b1, 8'h04, {24'h0, trk[i]});
      apb(1'b1, 8'h00, {24'h0, 6'b100000, i[0], 1'b0});
      wait_irq(100);
      chk(INNER_TRACK_FLAG, inner[i], "inner");
      chk(SIDE_SELECT_OUT, i[0], "side");
      apb(1'b0, 8'h00, 32'h0);
      chk({rd[`ST_NOTRDY], rd[`ST_ERR], rd[`ST_BUSY]}, 3'b000, "status");
      chk(INTERRUPT_REQUEST_LINE, 1'b0, "irq");
    end
    READY_IN <= 1'b0;
    repeat (2) @(posedge REF_CLK);
    apb(1'b1, 8'h00, 32'ha0);
    wait_irq(10);
    apb(1'b0, 8'h00, 32'h0);
    chk({rd[`ST_NOTRDY], rd[`ST_ERR], rd[`ST_BUSY]}, 3'b110, "status");
    chk(WRITE_GATE_OUT, 1'b0, "wgate");
    for (i = 0; i < 6; i++) begin
      base = steps;
      apb(1'b1, 8'h00, {24'h0, st[i][23:16]});
      wait_irq(400);
      apb(1'b0, 8'h04, 32'h0);
      chk(rd, {24'h0, st[i][15:8]}, "track");
      chk(steps - base, st[i][7:4], "steps");
      chk(DIR_OUT, st[i][0], "dir");
      chk(HEAD_LOAD_OUT, !st[i][19], "head");
      apb(1'b0, 8'h00, 32'h0);
    end
    apb(1'b1, 8'h0c, 32'h30);
    apb(1'b1, 8'h00, 32'h13);
    apb(1'b1, 8'h00, 32'h70);
    repeat (60) @(posedge REF_CLK);
    chk(DIR_OUT, 1'b1, "dir");
    chk(INTERRUPT_REQUEST_LINE, 1'b0, "irq");
    apb(1'b1, 8'h00, 32'hd1);
    READY_IN <= 1'b1;
    wait_irq(10);
    apb(1'b1, 8'h00, 32'hd4);
    wait_irq(600);
    apb(1'b1, 8'h00, 32'hd8);
    wait_irq(6);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd[`ST_BUSY], 1'b0, "busy");
    apb(1'b1, 8'h00, 32'hd0);
    repeat (20) @(posedge REF_CLK);
    chk(INTERRUPT_REQUEST_LINE, 1'b0, "irq");
    apb(1'b1, 8'h10, 32'h0304);
    apb(1'b1, 8'h00, 32'h8a);
    wait_irq(10);
    apb(1'b0, 8'h00, 32'h0);
    chk({rd[`ST_ERR], rd[`ST_SIDE]}, 2'b11, "status");
    chk(SIDE_SELECT_OUT, 1'b0, "side");
    apb(1'b1, 8'h10, 32'h0307);
    apb(1'b1, 8'h00, 32'h84);
    repeat (30) @(posedge REF_CLK);
    chk(INTERRUPT_REQUEST_LINE, 1'b0, "irq");
    wait_irq(20);
    apb(1'b1, 8'h10, 32'h0305);
    WPROT_N <= 1'b0;
    apb(1'b1, 8'h00, 32'ha0);
    wait_irq(20);
    apb(1'b0, 8'h00, 32'h0);
    chk({rd[`ST_WPROT], rd[`ST_BUSY]}, 2'b10, "status");
    chk(WRITE_GATE_OUT, 1'b0, "wgate");
    WPROT_N <= 1'b1;
    repeat (4) @(posedge REF_CLK);
    apb(1'b1, 8'h00, 32'ha0);
    repeat (30) @(posedge REF_CLK);
    chk(WRITE_GATE_OUT, 1'b1, "wgate");
    apb(1'b1, 8'h0c, 32'h00);
    n = 0;
    while (WRITE_DATA_OUT !== 1'b1 && n < 500) begin
      @(negedge REF_CLK);
      n = n + 1;
    end
    n = 0;
    while (WRITE_DATA_OUT === 1'b1 && n < 9) begin
      n = n + 1;
      @(negedge REF_CLK);
    end
    chk(n, 3, "pulse");
    chk(WRITE_GATE_OUT, 1'b1, "wgate");
    apb(1'b1, 8'h00, 32'hd0);
    repeat (10) @(posedge REF_CLK);
    chk(WRITE_GATE_OUT, 1'b0, "wgate");
    chk(INTERRUPT_REQUEST_LINE, 1'b0, "irq");
    final_report;
  end
endmodule // floppy_command_decoder_test
